// >>> rtl/burst_sram_defs.svh
// Shared constants for the burst cache SRAM cycle control
`ifndef BURST_SRAM_DEFS_SVH
`define BURST_SRAM_DEFS_SVH

// Array geometry
`define SRAM_ADDR_W 16
`define SRAM_HALF_W 9
`define SRAM_WORD_W 18
// Burst counter width, four beats before wrap
`define SRAM_BURST_W 2
// Frequency above which bursts are forbidden to the other party
`define SRAM_BURST_FMAX_MHZ 50
`define SRAM_CLK_MHZ 125

`endif

// >>> rtl/burst_sram_pkg.sv
// Types for the burst cache SRAM cycle control
package burst_sram_pkg;
   typedef enum logic [2:0]
   {
      CYC_IDLE = 3'b000,
      CYC_DESELECT = 3'b001,
      CYC_START_READ = 3'b010,
      CYC_START_WRITE = 3'b011,
      CYC_READ = 3'b100,
      CYC_WRITE = 3'b101
   } cycle_t;
endpackage

// >>> rtl/sram_half_bank.sv
// One nine-bit half of the storage array with its own write strobe
`timescale 1ns/1ns
`default_nettype none
module sram_half_bank
#(
   parameter int ADDR_W = 16,
   parameter int DATA_W = 9
)
(
   input wire logic sys_clk,
   input wire logic wr_en,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wr_data,
   output logic [DATA_W-1:0] rd_data
);
   // ==========================================
   // Storage
   logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

   initial
   begin
      if (ADDR_W < 1 || DATA_W < 1)
      begin
         $error("sram_half_bank: bad geometry");
      end
   end

   // Read before write, read registered; no reset since array contents are undefined
   always_ff @(posedge sys_clk)
   begin
      if (wr_en)
      begin
         mem[addr] <= wr_data;
      end
   end

   // Read data from flip-flops, follows the same address each cycle
   always_ff @(posedge sys_clk)
   begin
      rd_data <= mem[addr];
   end
endmodule
`default_nettype wire

// >>> rtl/burst_sram_cycle_control.sv
// Cycle decode, burst counter and output control of the burst cache SRAM
// Overview of operation
// - Select plus processor strobe starts burst read
// - Controller strobe with write low starts write
// - Deselected when select high, controller strobe low
// - Processor strobe ignored while select is high
// - Hold address and read, no advance
// - Advance address and read
// - Hold address and write
// - Advance address and write
// - No strobes, advance low, write: increment
// - No strobes, advance low, read: increment
// - No strobes, no advance: keep address
// - Sampled write enable tristates data outputs
// - Read data returns after write ends
// - High output enable floats outputs immediately
// - Low output enable drives outputs immediately once a read cycle has been sampled
// - Parity lines act as ordinary data bits
`timescale 1ns/1ns
`default_nettype none
`include "burst_sram_defs.svh"
module burst_sram_cycle_control
   import burst_sram_pkg::*;
#(
   parameter int ADDR_W = `SRAM_ADDR_W,
   parameter int HALF_W = `SRAM_HALF_W,
   parameter int BURST_W = `SRAM_BURST_W
)
(
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic chip_select_n,
   input wire logic processor_addr_strobe_n,
   input wire logic controller_addr_strobe_n,
   input wire logic burst_step_n,
   input wire logic write_upper_n,
   input wire logic write_lower_n,
   input wire logic output_enable_n,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [2*HALF_W-3:0] data_in,
   output logic [2*HALF_W-3:0] data_out,
   output logic [2*HALF_W-3:0] data_oe,
   input wire logic [1:0] parity_io_in,
   output logic [1:0] parity_io_out,
   output logic [1:0] parity_io_oe,
   output logic burst_allowed
);
   // ==========================================
   // Elaboration checks
   initial
   begin
      if (BURST_W < 1 || BURST_W >= ADDR_W || HALF_W < 2)
      begin
         $error("burst_sram_cycle_control: unsupported geometry");
      end
   end

   localparam int DQ_HALF = HALF_W - 1;

   // ==========================================
   // Cycle decode
   cycle_t next_cycle;
   cycle_t cycle;
   logic any_write_n;
   logic load_ext;
   logic step;
   logic active;

   assign any_write_n = write_upper_n & write_lower_n;

   // Truth-table priority: processor start, controller start, deselect, continue
   always_comb
   begin
      next_cycle = CYC_IDLE;
      load_ext = 1'b0;
      step = 1'b0;
      active = 1'b0;
      if (!chip_select_n && !processor_addr_strobe_n)
      begin
         next_cycle = CYC_START_READ;
         load_ext = 1'b1;
         active = 1'b1;
      end
      else if (!chip_select_n && !controller_addr_strobe_n)
      begin
         next_cycle = any_write_n ? CYC_START_READ : CYC_START_WRITE;
         load_ext = 1'b1;
         active = 1'b1;
      end
      else if (chip_select_n && !controller_addr_strobe_n)
      begin
         next_cycle = CYC_DESELECT;
      end
      else
      begin
         // Processor strobe plays no part here, so select high or low decode alike
         next_cycle = any_write_n ? CYC_READ : CYC_WRITE;
         step = !burst_step_n;
         active = 1'b1;
      end
   end

   // ==========================================
   // Address register and burst counter
   logic [ADDR_W-1:0] base_addr;
   logic [BURST_W-1:0] burst_cnt;
   logic [BURST_W-1:0] next_burst_cnt;
   logic [ADDR_W-1:0] cur_addr;

   // Counter wraps naturally at its width, giving four beats
   always_comb
   begin
      next_burst_cnt = burst_cnt;
      if (load_ext)
      begin
         next_burst_cnt = addr[BURST_W-1:0];
      end
      else if (step)
      begin
         next_burst_cnt = burst_cnt + 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         base_addr <= '0;
      end
      else if (load_ext)
      begin
         base_addr <= addr;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         burst_cnt <= '0;
      end
      else
      begin
         burst_cnt <= next_burst_cnt;
      end
   end

   // Address for the current cycle, combinational so the array sees it this edge
   assign cur_addr = load_ext ? addr : {base_addr[ADDR_W-1:BURST_W], next_burst_cnt};

   // ==========================================
   // Array halves
   logic wr_upper;
   logic wr_lower;
   logic [HALF_W-1:0] rd_upper;
   logic [HALF_W-1:0] rd_lower;
   logic [HALF_W-1:0] wd_upper;
   logic [HALF_W-1:0] wd_lower;

   // Start-of-burst via processor strobe ignores writes; no write is carried over to the next cycle
   assign wr_upper = active && !load_ext && !write_upper_n;
   assign wr_lower = active && !write_lower_n && !(load_ext && !processor_addr_strobe_n);
   // Parity bit is simply the top bit of each half
   assign wd_upper = {parity_io_in[1], data_in[2*DQ_HALF-1:DQ_HALF]};
   assign wd_lower = {parity_io_in[0], data_in[DQ_HALF-1:0]};

   // Upper half also needs controller-start writes
   logic wr_upper_q;
   assign wr_upper_q = wr_upper || (load_ext && processor_addr_strobe_n && !write_upper_n);

   sram_half_bank #(
      .ADDR_W(ADDR_W),
      .DATA_W(HALF_W)
   ) upper_bank (
      .sys_clk(sys_clk),
      .wr_en(wr_upper_q),
      .addr(cur_addr),
      .wr_data(wd_upper),
      .rd_data(rd_upper)
   );

   sram_half_bank #(
      .ADDR_W(ADDR_W),
      .DATA_W(HALF_W)
   ) lower_bank (
      .sys_clk(sys_clk),
      .wr_en(wr_lower),
      .addr(cur_addr),
      .wr_data(wd_lower),
      .rd_data(rd_lower)
   );

   // ==========================================
   // Output control
   logic drive_q;

   // Reads drive after the edge; sampled writes or deselect float the bus
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         drive_q <= 1'b0;
      end
      else if (!any_write_n)
      begin
         drive_q <= 1'b0;
      end
      else
      begin
         drive_q <= (next_cycle != CYC_DESELECT);
      end
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         cycle <= CYC_IDLE;
      end
      else
      begin
         cycle <= next_cycle;
      end
   end

   // Output enable is asynchronous: it gates the registered drive with no clock
   always_comb
   begin
      data_out = {rd_upper[DQ_HALF-1:0], rd_lower[DQ_HALF-1:0]};
      parity_io_out = {rd_upper[HALF_W-1], rd_lower[HALF_W-1]};
      data_oe = {(2*DQ_HALF){drive_q && !output_enable_n}};
      parity_io_oe = {2{drive_q && !output_enable_n}};
   end

   // Advisory level for the far side, which must avoid bursts above the limit
   assign burst_allowed = (`SRAM_CLK_MHZ <= `SRAM_BURST_FMAX_MHZ);
endmodule
`default_nettype wire

// >>> tb/burst_sram_checker.sv
// Port assertions for the burst SRAM cycle control
`timescale 1ns/1ns
`default_nettype none
module burst_sram_checker
(
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic chip_select_n,
   input wire logic processor_addr_strobe_n,
   input wire logic controller_addr_strobe_n,
   input wire logic burst_step_n,
   input wire logic write_upper_n,
   input wire logic write_lower_n,
   input wire logic output_enable_n,
   input wire logic [15:0] data_oe,
   input wire logic [1:0] parity_io_oe,
   input wire logic burst_allowed
);
   // ==========
   // Properties
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   wire logic rd_n = write_upper_n & write_lower_n;
   wire logic pstart = !chip_select_n & !processor_addr_strobe_n;
   property p_oe_off;
      output_enable_n |-> data_oe == 16'h0000 && parity_io_oe == 2'b00;
   endproperty
   a_oe_off: assert property (p_oe_off) else $error("oe high yet driving");
   property p_start_drive;
      pstart && rd_n ##1 !output_enable_n |-> &data_oe;
   endproperty
   a_start_drive: assert property (p_start_drive) else $error("read start not driven");
   property p_wr_float;
      !pstart && !rd_n |=> data_oe == 16'h0000;
   endproperty
   a_wr_float: assert property (p_wr_float) else $error("write not floated");
   property p_proc_ignored;
      chip_select_n && !processor_addr_strobe_n && controller_addr_strobe_n && !rd_n
      |=> data_oe == 16'h0000;
   endproperty
   a_proc_ignored: assert property (p_proc_ignored) else $error("strobe not ignored");
   property p_desel;
      chip_select_n && !controller_addr_strobe_n |=> data_oe == 16'h0000;
   endproperty
   a_desel: assert property (p_desel) else $error("deselect drives");
   property p_wr_back;
      !rd_n && processor_addr_strobe_n && !(chip_select_n && !controller_addr_strobe_n)
      ##1 rd_n && processor_addr_strobe_n && controller_addr_strobe_n
      ##1 !output_enable_n |-> &data_oe;
   endproperty
   a_wr_back: assert property (p_wr_back) else $error("read not restored");
   property p_parity;
      parity_io_oe == {data_oe[15], data_oe[0]};
   endproperty
   a_parity: assert property (p_parity) else $error("parity enable differs");
   property p_no_burst;
      burst_allowed == 1'b0;
   endproperty
   a_no_burst: assert property (p_no_burst) else $error("burst allowed at speed");
   c_pstart: cover property (pstart);
   c_cwrite: cover property (!chip_select_n && !controller_addr_strobe_n && !rd_n);
   c_step: cover property (!burst_step_n && processor_addr_strobe_n);
endmodule
bind burst_sram_cycle_control burst_sram_checker i_chk (.*);
`default_nettype wire

// >>> tb/far_side_bus.sv
// Far-side data bus model of the cache controller
`timescale 1ns/1ns
`default_nettype none
module far_side_bus
(
   input wire logic drive,
   input wire logic [17:0] val,
   input wire logic [17:0] dev_oe,
   input wire logic [17:0] dev_val,
   output logic [17:0] bus
);
   // ==========
   // Bus level
   logic [17:0] last = 18'h0_0000;
   // Remember what we drove; released lines show its inverse, not a stale copy
   always @(drive, val)
      if (drive)
         last = val;
   always_comb
      for (int i = 0; i < 18; i++)
         bus[i] = dev_oe[i] ? dev_val[i] : (drive ? val[i] : ~last[i]);
endmodule
`default_nettype wire

// >>> tb/burst_sram_cycle_control_bench.sv
// Self-checking bench for the burst SRAM cycle control
`timescale 1ns/1ns
`default_nettype none
module burst_sram_cycle_control_bench;
   // ==========
   // Signals
   logic sys_clk = 1'b0;
   logic rstn = 1'b0;
   logic chip_select_n = 1'b1;
   logic processor_addr_strobe_n = 1'b1;
   logic controller_addr_strobe_n = 1'b1;
   logic burst_step_n = 1'b1;
   logic write_upper_n = 1'b1;
   logic write_lower_n = 1'b1;
   logic output_enable_n = 1'b0;
   logic [15:0] addr = 16'h0000;
   logic drv = 1'b0;
   logic [17:0] wval = 18'h0_0000;
   logic [15:0] cur = 16'h0000;
   logic [17:0] mem [int];
   int n_fail = 0;
   int cmp_count = 0;
   wire logic [17:0] bus;
   wire logic [15:0] data_in = {bus[16:9], bus[7:0]};
   wire logic [1:0] parity_io_in = {bus[17], bus[8]};
   logic [15:0] data_out;
   logic [15:0] data_oe;
   logic [1:0] parity_io_out;
   logic [1:0] parity_io_oe;
   logic burst_allowed;
   wire logic [17:0] rd_w = {parity_io_out[1], data_out[15:8], parity_io_out[0], data_out[7:0]};
   wire logic [17:0] oe_w = {parity_io_oe[1], data_oe[15:8], parity_io_oe[0], data_oe[7:0]};
   burst_sram_cycle_control i_dut (.*);
   far_side_bus i_far (.drive(drv), .val(wval), .dev_oe(oe_w), .dev_val(rd_w), .bus(bus));
   initial
      forever #4 sys_clk = ~sys_clk;
   // ==========
   // Tasks
   task automatic chk(input string nm, input logic [17:0] e, input logic [17:0] g);
      cmp_count++;
      if (g !== e)
      begin
         n_fail++;
         $display("MISMATCH %s exp %h got %h", nm, e, g);
      end
   endtask
   // c = {cs, proc, ctrl, step, upper, lower}; a hold-read follows so checks settle
   task automatic op(input logic [5:0] c, input logic [15:0] a, input logic [17:0] w);
      logic ps;
      logic des;
      ps = !c[5] && !c[4];
      des = c[5] && !c[3];
      if (ps || (!c[5] && !c[3]))
         cur = a;
      else if (!des && !c[2])
         cur[1:0] = cur[1:0] + 2'b01;
      if (!des && !ps && !c[1])
         mem[cur][17:9] = w[17:9];
      if (!des && !ps && !c[0])
         mem[cur][8:0] = w[8:0];
      @(posedge sys_clk);
      {chip_select_n, processor_addr_strobe_n, controller_addr_strobe_n} <= c[5:3];
      {burst_step_n, write_upper_n, write_lower_n} <= c[2:0];
      addr <= a;
      wval <= w;
      drv <= ~&c[1:0];
      // Float the device while we drive write data, avoiding bus contention
      output_enable_n <= ~&c[1:0];
      @(posedge sys_clk);
      output_enable_n <= 1'b0;
      {processor_addr_strobe_n, controller_addr_strobe_n, burst_step_n} <= 3'b111;
      {write_upper_n, write_lower_n, drv} <= 3'b110;
      #1;
      if (!des && &c[1:0])
         chk("read", mem[cur], rd_w);
   endtask
   // Burst writes wrapping from the top beat, then half writes
   task automatic t_write;
      op(6'b010100, 16'h1233, 18'h2_a5c3);
      op(6'b101000, 16'hffff, 18'h1_3c96);
      op(6'b011000, 16'hffff, 18'h0_7e11);
      op(6'b111101, 16'hffff, 18'h3_0000);
      op(6'b101110, 16'hffff, 18'h0_01ff);
   endtask
   // Burst reads through every continuation kind
   task automatic t_read;
      op(6'b001111, 16'h1233, 18'h0_0000);
      op(6'b101011, 16'h0000, 18'h0_0000);
      op(6'b011011, 16'h0000, 18'h0_0000);
      op(6'b101111, 16'h0000, 18'h0_0000);
      op(6'b111111, 16'h0000, 18'h0_0000);
      op(6'b010111, 16'h1230, 18'h0_0000);
   endtask
   // Deselect with write and step low must leave the array alone
   task automatic t_desel;
      op(6'b110000, 16'h1230, 18'h3_ffff);
      op(6'b001111, 16'h1230, 18'h0_0000);
   endtask
   // Output enable gates the drive between clock edges
   task automatic t_oe;
      @(posedge sys_clk);
      output_enable_n <= 1'b1;
      #2 chk("oe off", 18'h0_0000, oe_w);
      @(posedge sys_clk);
      output_enable_n <= 1'b0;
      #2 chk("oe on", 18'h3_ffff, oe_w);
   endtask
   task automatic finish_test;
      $display("Compares %0d, mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // ==========
   // Sequence and watchdog
   initial
   begin
      repeat (12) @(posedge sys_clk);
      rstn <= 1'b1;
      t_write();
      t_read();
      t_desel();
      t_oe();
      finish_test();
   end
   initial
   begin
      #(2000 * 8);
      n_fail++;
      finish_test();
   end
endmodule
`default_nettype wire
